// ===== design/gdcr_device.sv
// Gate driver control registers: output level and predriver enable banks.
// Assumes a host on the register port and pins from the analog front end.
`timescale 1ns/1ps
`default_nettype none
module gdcr_device (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	gdcr_if.device port_if,
	input wire logic driver_off_pin_i,
	input wire logic fault_indicator_n_i,
	input wire logic predriver_fault_i,
	input wire logic gate_supply_undervoltage_flag_i,
	input wire logic all_channel_shutdown_i,
	input wire logic gate_supply_uv_response_i,
	input wire logic [2:0] high_side_pwm_input_i,
	input wire logic [2:0] low_side_pwm_input_i,
	input wire logic [3:0] source_current_setting_i,
	input wire logic [3:0] sink_current_setting_i,
	output logic output_level_5v_o,
	output logic [2:0] gate_high_o,
	output logic [2:0] gate_low_o,
	output logic [3:0] source_current_o,
	output logic [3:0] sink_current_o,
	output logic amplifier_on_o,
	output logic amplifier_outputs_hiz_o,
	output logic autozero_active_o,
	output logic pump_softstart_off_o,
	output logic gate_supply_ldo_force_o,
	output logic pump_clock_stop_o
);

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	logic [9:0] pins_s;
	logic driver_off_s;
	logic fault_n_s;
	logic pfault_s;
	logic uv_s;
	logic [2:0] hs_s;
	logic [2:0] ls_s;

	gdcr_sync3 #(
		.WIDTH(10)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.async_i({driver_off_pin_i, fault_indicator_n_i, predriver_fault_i,
			gate_supply_undervoltage_flag_i, high_side_pwm_input_i, low_side_pwm_input_i}),
		.sync_o(pins_s)
	);

	assign driver_off_s = pins_s[9];
	assign fault_n_s = pins_s[8];
	assign pfault_s = pins_s[7];
	assign uv_s = pins_s[6];
	assign hs_s = pins_s[5:3];
	assign ls_s = pins_s[2:0];

	// ----------------------------------------------------------------
	// Register port decode
	// ----------------------------------------------------------------
	logic ack_q;
	logic take;
	logic wr_level;
	logic wr_enable;

	assign take = port_if.req && !ack_q;
	assign wr_level = take && port_if.we && (port_if.addr == gdcr_pkg::OUTPUT_LEVEL_CONTROL_OFS);
	assign wr_enable = take && port_if.we && (port_if.addr == gdcr_pkg::DRIVER_ENABLE_CONTROL_OFS);

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= take;
		end
	end
	assign port_if.ack = ack_q;

	// ----------------------------------------------------------------
	// Output level control
	// ----------------------------------------------------------------
	logic level_sel_q;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			level_sel_q <= gdcr_pkg::OUTPUT_LEVEL_CONTROL_RST[gdcr_pkg::OUTPUT_LEVEL_SELECT_POS];
		end else if (wr_level) begin
			level_sel_q <= port_if.wdata[gdcr_pkg::OUTPUT_LEVEL_SELECT_POS];
		end
	end

	// Drives the output supply only; no input buffer control exists
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			output_level_5v_o <= 1'b0;
		end else begin
			output_level_5v_o <= level_sel_q;
		end
	end

	// ----------------------------------------------------------------
	// Predriver enable
	// ----------------------------------------------------------------
	logic powerup_hold_q;
	logic enable_q;
	logic force_off;

	// Released once the fault indicator has gone high after reset
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			powerup_hold_q <= 1'b1;
		end else if (fault_n_s) begin
			powerup_hold_q <= 1'b0;
		end
	end

	assign force_off = (pfault_s && all_channel_shutdown_i) || driver_off_s;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			enable_q <= gdcr_pkg::DRIVER_ENABLE_CONTROL_RST[gdcr_pkg::PREDRIVER_ENABLE_POS];
		end else if (force_off) begin
			enable_q <= 1'b0;
		end else if (wr_enable && !powerup_hold_q) begin
			enable_q <= port_if.wdata[gdcr_pkg::PREDRIVER_ENABLE_POS];
		end
	end

	// ----------------------------------------------------------------
	// Amplifier and gate supply control
	// ----------------------------------------------------------------
	logic amp_en_q;
	logic az_dis_q;
	logic ss_dis_q;
	logic ldo_q;
	logic amp_uv_off;

	assign amp_uv_off = gate_supply_uv_response_i && uv_s;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			amp_en_q <= gdcr_pkg::DRIVER_ENABLE_CONTROL_RST[gdcr_pkg::AMPLIFIER_ENABLE_POS];
		end else if (amp_uv_off) begin
			amp_en_q <= 1'b0;
		end else if (wr_enable) begin
			amp_en_q <= port_if.wdata[gdcr_pkg::AMPLIFIER_ENABLE_POS];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			az_dis_q <= gdcr_pkg::DRIVER_ENABLE_CONTROL_RST[gdcr_pkg::AUTOZERO_DISABLE_POS];
			ss_dis_q <= gdcr_pkg::DRIVER_ENABLE_CONTROL_RST[gdcr_pkg::PUMP_SOFTSTART_DISABLE_POS];
			ldo_q <= gdcr_pkg::DRIVER_ENABLE_CONTROL_RST[gdcr_pkg::GATE_SUPPLY_LDO_FORCE_POS];
		end else if (wr_enable) begin
			az_dis_q <= port_if.wdata[gdcr_pkg::AUTOZERO_DISABLE_POS];
			ss_dis_q <= port_if.wdata[gdcr_pkg::PUMP_SOFTSTART_DISABLE_POS];
			ldo_q <= port_if.wdata[gdcr_pkg::GATE_SUPPLY_LDO_FORCE_POS];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			amplifier_on_o <= 1'b0;
			amplifier_outputs_hiz_o <= 1'b1;
			autozero_active_o <= 1'b1;
			pump_softstart_off_o <= 1'b0;
			gate_supply_ldo_force_o <= 1'b0;
			pump_clock_stop_o <= 1'b0;
		end else begin
			amplifier_on_o <= amp_en_q;
			amplifier_outputs_hiz_o <= !amp_en_q;
			autozero_active_o <= !az_dis_q;
			pump_softstart_off_o <= ss_dis_q;
			gate_supply_ldo_force_o <= ldo_q;
			pump_clock_stop_o <= ldo_q;
		end
	end

	// ----------------------------------------------------------------
	// Gate outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gate_high_o <= 3'h0;
			gate_low_o <= 3'h0;
		end else if (enable_q) begin
			gate_high_o <= hs_s;
			gate_low_o <= ls_s;
		end else begin
			gate_high_o <= 3'h0;
			gate_low_o <= 3'h0;
		end
	end

	// ----------------------------------------------------------------
	// Gate current update, staged across one PWM period while the predriver is enabled
	// ----------------------------------------------------------------
	logic hs0_prev_q;
	logic pwm_start;
	logic [7:0] stage_q;

	assign pwm_start = hs_s[0] && !hs0_prev_q;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hs0_prev_q <= 1'b0;
		end else begin
			hs0_prev_q <= hs_s[0];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stage_q <= 8'h00;
			source_current_o <= 4'h0;
			sink_current_o <= 4'h0;
		end else if (!enable_q) begin
			stage_q <= {source_current_setting_i, sink_current_setting_i};
			source_current_o <= source_current_setting_i;
			sink_current_o <= sink_current_setting_i;
		end else if (pwm_start) begin
			stage_q <= {source_current_setting_i, sink_current_setting_i};
			source_current_o <= stage_q[7:4];
			sink_current_o <= stage_q[3:0];
		end
	end

	// ----------------------------------------------------------------
	// Read back
	// ----------------------------------------------------------------
	logic [15:0] rdata_q;
	logic [15:0] level_word;
	logic [15:0] enable_word;

	assign level_word = {15'h0000, level_sel_q};
	assign enable_word = {enable_q, 3'h0, amp_en_q, az_dis_q, ss_dis_q, ldo_q, 8'h00}
		| gdcr_pkg::DRIVER_ENABLE_FIXED_BITS;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_q <= 16'h0000;
		end else if (take) begin
			case (port_if.addr)
				gdcr_pkg::OUTPUT_LEVEL_CONTROL_OFS: begin
					rdata_q <= level_word;
				end
				gdcr_pkg::DRIVER_ENABLE_CONTROL_OFS: begin
					rdata_q <= enable_word;
				end
				default: begin
					rdata_q <= 16'h0000;
				end
			endcase
		end
	end
	assign port_if.rdata = rdata_q;

endmodule // gdcr_device
`default_nettype wire

// ===== design/gdcr_pkg.sv
// Shared constants of the gate driver control register pair and its host.
// Assumes a single 25 MHz system clock for both ends.
package gdcr_pkg;

	// ----------------------------------------------------------------
	// Device register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OUTPUT_LEVEL_CONTROL_OFS = 8'h1a;
	localparam logic [7:0] DRIVER_ENABLE_CONTROL_OFS = 8'h1b;
	localparam logic [15:0] OUTPUT_LEVEL_CONTROL_RST = 16'h0000;
	localparam logic [15:0] DRIVER_ENABLE_CONTROL_RST = 16'h0006;
	localparam int OUTPUT_LEVEL_SELECT_POS = 0;
	localparam int PREDRIVER_ENABLE_POS = 15;
	localparam int AMPLIFIER_ENABLE_POS = 11;
	localparam int AUTOZERO_DISABLE_POS = 10;
	localparam int PUMP_SOFTSTART_DISABLE_POS = 9;
	localparam int GATE_SUPPLY_LDO_FORCE_POS = 8;
	// Lock field default, readable but not modelled here
	localparam logic [15:0] DRIVER_ENABLE_FIXED_BITS = 16'h0006;

	// ----------------------------------------------------------------
	// Host register map, word index on the Avalon-MM slave
	// ----------------------------------------------------------------
	localparam logic [2:0] HOST_TARGET_OFS = 3'h0;
	localparam logic [2:0] HOST_WDATA_OFS = 3'h1;
	localparam logic [2:0] HOST_COMMAND_OFS = 3'h2;
	localparam logic [2:0] HOST_RDATA_OFS = 3'h3;
	localparam logic [2:0] HOST_CONFIG_OFS = 3'h4;
	localparam logic [2:0] HOST_IRQ_STATUS_OFS = 3'h5;
	localparam logic [2:0] HOST_IRQ_CLEAR_OFS = 3'h6;
	localparam logic [2:0] HOST_IRQ_ENABLE_OFS = 3'h7;
	localparam int CMD_START_POS = 0;
	localparam int CMD_READ_POS = 1;
	localparam int CFG_MONITOR_READY_POS = 0;
	localparam int CFG_CURRENTS_READY_POS = 1;
	localparam int CFG_ALLOW_AZ_DIS_POS = 2;
	localparam int CFG_BUSY_POS = 3;
	localparam int IRQ_DONE_POS = 0;
	localparam int IRQ_REFUSED_POS = 1;
	localparam int IRQ_FAULT_RELEASE_POS = 2;
	localparam int IRQ_WIDTH = 3;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_HZ = 25000000;
	localparam int ENABLE_SETTLE_NS = 5000;
	localparam int ENABLE_SETTLE_CYCLES =
		(ENABLE_SETTLE_NS * (CLK_FREQ_HZ / 1000000) + 999) / 1000;

	typedef enum logic [1:0] {
		HOST_IDLE = 2'b00,
		HOST_SETTLE = 2'b01,
		HOST_ISSUE = 2'b10
	} gdcr_host_state_type;

endpackage

// ===== design/gdcr_if.sv
// Register port between host controller and gate driver register bank.
// Assumes both ends share clk_sys_i; the request is held until acknowledged.
`timescale 1ns/1ps
`default_nettype none
interface gdcr_if;
	logic req;
	logic we;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic ack;
	logic [15:0] rdata;

	modport device (input req, input we, input addr, input wdata, output ack, output rdata);
	modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

// ===== design/gdcr_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module gdcr_sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Change accepted once stages two and three agree
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync_o <= '0;
		end else begin
			sync_o <= (s2_q & s3_q) | (sync_o & (s2_q | s3_q));
		end
	end
endmodule // gdcr_sync3
`default_nettype wire

// ===== design/gdcr_host.sv
// Host controller: Avalon-MM slave that issues register port transfers.
// Assumes the device end on gdcr_if and the same clock.
`timescale 1ns/1ps
`default_nettype none
module gdcr_host (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	gdcr_if.host port_if,
	input wire logic [2:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	input wire logic fault_indicator_n_i,
	input wire logic gate_supply_undervoltage_flag_i,
	input wire logic gate_supply_uv_response_i
);

	// ----------------------------------------------------------------
	// Avalon slave handshake, one wait cycle per access
	// ----------------------------------------------------------------
	logic wr;

	assign wr = avs_write_i && !avs_waitrequest_o;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
		end
	end

	// ----------------------------------------------------------------
	// Pins and settle timer
	// ----------------------------------------------------------------
	logic [1:0] pins_s;
	logic fault_n_prev_q;
	logic [7:0] settle_q;
	logic settled;

	gdcr_sync3 #(
		.WIDTH(2)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.async_i({fault_indicator_n_i, gate_supply_undervoltage_flag_i}),
		.sync_o(pins_s)
	);

	assign settled = (settle_q == 8'(gdcr_pkg::ENABLE_SETTLE_CYCLES));

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			settle_q <= 8'h00;
			fault_n_prev_q <= 1'b0;
		end else begin
			fault_n_prev_q <= pins_s[1];
			if (!pins_s[1]) begin
				settle_q <= 8'h00;
			end else if (!settled) begin
				settle_q <= settle_q + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	logic [7:0] target_q;
	logic [15:0] wdata_q;
	logic [2:0] cfg_q;
	logic [15:0] rdata_q;
	logic [2:0] irq_en_q;
	logic [2:0] irq_stat_q;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			target_q <= 8'h00;
			wdata_q <= 16'h0000;
			cfg_q <= 3'h0;
			irq_en_q <= 3'h0;
		end else if (wr) begin
			case (avs_address_i)
				gdcr_pkg::HOST_TARGET_OFS: target_q <= avs_writedata_i[7:0];
				gdcr_pkg::HOST_WDATA_OFS: wdata_q <= avs_writedata_i[15:0];
				gdcr_pkg::HOST_CONFIG_OFS: cfg_q <= avs_writedata_i[2:0];
				gdcr_pkg::HOST_IRQ_ENABLE_OFS: irq_en_q <= avs_writedata_i[2:0];
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	gdcr_pkg::gdcr_host_state_type state_q;
	logic cmd;
	logic cmd_rd;
	logic is_enable_reg;
	logic refuse;
	logic [15:0] out_data;
	logic done_ev;
	logic refuse_ev;

	assign cmd = wr && (avs_address_i == gdcr_pkg::HOST_COMMAND_OFS)
		&& avs_writedata_i[gdcr_pkg::CMD_START_POS];
	assign cmd_rd = avs_writedata_i[gdcr_pkg::CMD_READ_POS];
	assign is_enable_reg = (target_q == gdcr_pkg::DRIVER_ENABLE_CONTROL_OFS);
	assign refuse = (state_q != gdcr_pkg::HOST_IDLE) || (!cmd_rd && (
		((target_q == gdcr_pkg::OUTPUT_LEVEL_CONTROL_OFS)
			&& wdata_q[gdcr_pkg::OUTPUT_LEVEL_SELECT_POS]
			&& !cfg_q[gdcr_pkg::CFG_MONITOR_READY_POS])
		|| (is_enable_reg && wdata_q[gdcr_pkg::PREDRIVER_ENABLE_POS]
			&& !cfg_q[gdcr_pkg::CFG_CURRENTS_READY_POS])
		|| (is_enable_reg && wdata_q[gdcr_pkg::AMPLIFIER_ENABLE_POS]
			&& !gate_supply_uv_response_i && pins_s[0])));

	always_comb begin
		out_data = wdata_q;
		if (is_enable_reg) begin
			out_data[gdcr_pkg::PUMP_SOFTSTART_DISABLE_POS] = 1'b1;
			out_data[gdcr_pkg::AUTOZERO_DISABLE_POS] = wdata_q[gdcr_pkg::AUTOZERO_DISABLE_POS]
				&& cfg_q[gdcr_pkg::CFG_ALLOW_AZ_DIS_POS];
		end
	end

	assign done_ev = (state_q == gdcr_pkg::HOST_ISSUE) && port_if.ack;
	assign refuse_ev = cmd && refuse;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= gdcr_pkg::HOST_IDLE;
			port_if.req <= 1'b0;
			port_if.we <= 1'b0;
			port_if.addr <= 8'h00;
			port_if.wdata <= 16'h0000;
			rdata_q <= 16'h0000;
		end else begin
			case (state_q)
				gdcr_pkg::HOST_IDLE: begin
					if (cmd && !refuse) begin
						port_if.we <= !cmd_rd;
						port_if.addr <= target_q;
						port_if.wdata <= out_data;
						if (!cmd_rd && is_enable_reg && wdata_q[gdcr_pkg::PREDRIVER_ENABLE_POS]) begin
							state_q <= gdcr_pkg::HOST_SETTLE;
						end else begin
							state_q <= gdcr_pkg::HOST_ISSUE;
							port_if.req <= 1'b1;
						end
					end
				end
				gdcr_pkg::HOST_SETTLE: begin
					if (settled) begin
						state_q <= gdcr_pkg::HOST_ISSUE;
						port_if.req <= 1'b1;
					end
				end
				gdcr_pkg::HOST_ISSUE: begin
					if (port_if.ack) begin
						port_if.req <= 1'b0;
						state_q <= gdcr_pkg::HOST_IDLE;
						if (!port_if.we) begin
							rdata_q <= port_if.rdata;
						end
					end
				end
				default: begin
					state_q <= gdcr_pkg::HOST_IDLE;
					port_if.req <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Interrupts, set wins over clear
	// ----------------------------------------------------------------
	logic [2:0] irq_set;
	logic [2:0] irq_clr;

	assign irq_set = {pins_s[1] && !fault_n_prev_q, refuse_ev, done_ev};
	assign irq_clr = (wr && (avs_address_i == gdcr_pkg::HOST_IRQ_CLEAR_OFS))
		? avs_writedata_i[2:0] : 3'h0;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_stat_q <= 3'h0;
			irq_o <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
			irq_o <= |(irq_stat_q & irq_en_q);
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
			case (avs_address_i)
				gdcr_pkg::HOST_TARGET_OFS: avs_readdata_o <= {24'h000000, target_q};
				gdcr_pkg::HOST_WDATA_OFS: avs_readdata_o <= {16'h0000, wdata_q};
				gdcr_pkg::HOST_RDATA_OFS: avs_readdata_o <= {16'h0000, rdata_q};
				gdcr_pkg::HOST_CONFIG_OFS: avs_readdata_o <=
					{28'h0000000, state_q != gdcr_pkg::HOST_IDLE, cfg_q};
				gdcr_pkg::HOST_IRQ_STATUS_OFS: avs_readdata_o <= {29'h00000000, irq_stat_q};
				gdcr_pkg::HOST_IRQ_ENABLE_OFS: avs_readdata_o <= {29'h00000000, irq_en_q};
				default: avs_readdata_o <= 32'h0000_0000;
			endcase
		end
	end

endmodule // gdcr_host
`default_nettype wire

// ===== dv/gdcr_props.sv
// Checker on the register port between host and device ends.
// Assumes it sits beside gdcr_if with the shared clock and reset.
`timescale 1ns/1ps
`default_nettype none
module gdcr_props (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic ack,
	input wire logic [15:0] rdata
);
	logic level_q;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	// Shadow of the level select bit
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			level_q <= 1'b0;
		end else if (req && !ack && we && addr == 8'h1a) begin
			level_q <= wdata[0];
		end
	end
	sequence s_taken;
		req && !ack;
	endsequence
	sequence s_answer;
		ack ##1 !ack;
	endsequence
	sequence s_rd(logic [7:0] a);
		ack && !we && addr == a;
	endsequence
	a_answer_next: assert property (s_taken |=> s_answer)
		else $error("ack missing after request");
	a_ack_caused: assert property (ack |-> $past(req && !ack))
		else $error("ack without request");
	a_req_held: assert property (s_taken |=> req && $stable(addr) && $stable(we) && $stable(wdata))
		else $error("request changed before ack");
	a_req_dropped: assert property (ack |=> !req)
		else $error("request kept after ack");
	a_rdata_stands: assert property (!req || ack |=> $stable(rdata))
		else $error("read data moved without request");
	a_level_readback: assert property (s_rd(8'h1a) |-> rdata == {15'h0000, level_q})
		else $error("level register read back wrong");
	a_ctrl2_fixed: assert property (s_rd(8'h1b) |-> rdata[14:12] == 3'h0 && rdata[5:1] == 5'h03)
		else $error("fixed bits of enable register wrong");
	a_unmapped_zero: assert property (ack && !we && addr != 8'h1a && addr != 8'h1b |-> rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_softstart_forced: assert property (s_taken and (we && addr == 8'h1b) |-> wdata[9])
		else $error("soft start disable not set");
endmodule // gdcr_props
`default_nettype wire

// ===== dv/tb.sv
// Bench joining host and device ends over the register port.
// Assumes design files and gdcr_props are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys_i, rstn_i, drv_off, flt_n, pd_flt, uv, all_channel_shutdown, uv_fm, a_rd, a_wr, a_wait, irq;
	logic lvl, amp_on, hiz, az, ss, ldo, pstop;
	logic [2:0] hs, ls, a_addr, gh, gl;
	logic [3:0] src, snk, sco, sko;
	logic [15:0] w;
	logic [31:0] a_wd, a_rdata, q;
	int err_count, cmp_count;
	gdcr_if gdcr_if_inst();
	gdcr_host gdcr_host_inst (.clk_sys_i, .rstn_i, .port_if(gdcr_if_inst.host),
		.avs_address_i(a_addr), .avs_read_i(a_rd), .avs_write_i(a_wr),
		.avs_writedata_i(a_wd), .avs_readdata_o(a_rdata), .avs_waitrequest_o(a_wait),
		.irq_o(irq), .fault_indicator_n_i(flt_n), .gate_supply_undervoltage_flag_i(uv),
		.gate_supply_uv_response_i(uv_fm));
	gdcr_device gdcr_device_inst (.clk_sys_i, .rstn_i, .port_if(gdcr_if_inst.device),
		.driver_off_pin_i(drv_off), .fault_indicator_n_i(flt_n), .predriver_fault_i(pd_flt),
		.gate_supply_undervoltage_flag_i(uv), .all_channel_shutdown_i(all_channel_shutdown),
		.gate_supply_uv_response_i(uv_fm), .high_side_pwm_input_i(hs),
		.low_side_pwm_input_i(ls), .source_current_setting_i(src),
		.sink_current_setting_i(snk), .output_level_5v_o(lvl), .gate_high_o(gh),
		.gate_low_o(gl), .source_current_o(sco), .sink_current_o(sko),
		.amplifier_on_o(amp_on),
		.amplifier_outputs_hiz_o(hiz), .autozero_active_o(az), .pump_softstart_off_o(ss),
		.gate_supply_ldo_force_o(ldo), .pump_clock_stop_o(pstop));
	gdcr_props gdcr_props_inst (.clk_sys_i, .rstn_i, .req(gdcr_if_inst.req),
		.we(gdcr_if_inst.we), .addr(gdcr_if_inst.addr), .wdata(gdcr_if_inst.wdata),
		.ack(gdcr_if_inst.ack), .rdata(gdcr_if_inst.rdata));
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		a_wr <= wr;
		a_rd <= !wr;
		a_addr <= a;
		a_wd <= d;
		do @(posedge clk_sys_i); while (a_wait !== 1'b0);
		q = a_rdata;
		a_wr <= 1'b0;
		a_rd <= 1'b0;
	endtask
	task automatic idle();
		do av(1'b0, gdcr_pkg::HOST_CONFIG_OFS, 32'h0); while (q[3] !== 1'b0);
	endtask
	task automatic start(input logic [7:0] a, input logic rd, input logic [15:0] d);
		av(1'b1, gdcr_pkg::HOST_TARGET_OFS, 32'(a));
		av(1'b1, gdcr_pkg::HOST_WDATA_OFS, 32'(d));
		av(1'b1, gdcr_pkg::HOST_COMMAND_OFS, {30'h0, rd, 1'b1});
	endtask
	task automatic dev(input logic [7:0] a, input logic rd, input logic [15:0] d);
		start(a, rd, d);
		idle();
		av(1'b0, gdcr_pkg::HOST_RDATA_OFS, 32'h0);
	endtask
	task automatic irqs(input logic [31:0] e);
		av(1'b0, gdcr_pkg::HOST_IRQ_STATUS_OFS, 32'h0);
		chk(q & 32'h7, e);
		av(1'b1, gdcr_pkg::HOST_IRQ_CLEAR_OFS, 32'h7);
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		cyc(20000);
		err_count++;
		end_sim();
	end
	initial begin
		{rstn_i, drv_off, flt_n, pd_flt, uv, all_channel_shutdown, uv_fm, a_rd, a_wr, a_addr, a_wd} = '0;
		{hs, ls, src, snk, w} = '0;
		err_count = 0;
		cmp_count = 0;
		void'($urandom(51));
		cyc(2);
		rstn_i <= 1'b1;
		chk(32'({amp_on, hiz, az, ss, ldo, pstop, lvl}), 32'h30);
		dev(8'h1a, 1'b1, 16'h0);
		chk(q, 32'h0);
		dev(8'h1b, 1'b1, 16'h0);
		chk(q & 32'hff3e, 32'h0006);
		dev(8'h40, 1'b1, 16'h0);
		chk(q, 32'h0);
		av(1'b1, gdcr_pkg::HOST_IRQ_ENABLE_OFS, 32'h7);
		av(1'b1, gdcr_pkg::HOST_IRQ_CLEAR_OFS, 32'h7);
		dev(8'h1a, 1'b0, 16'hffff);
		chk(32'({irq, lvl}), 32'h2);
		irqs(32'h2);
		cyc(2);
		chk(32'(irq), 32'h0);
		av(1'b1, gdcr_pkg::HOST_IRQ_ENABLE_OFS, 32'h0);
		av(1'b1, gdcr_pkg::HOST_CONFIG_OFS, 32'h3);
		for (int i = 1; i >= 0; i--) begin
			w = 16'($urandom());
			w[0] = i[0];
			dev(8'h1a, 1'b0, w);
			chk(32'({irq, lvl}), 32'(i[0]));
			dev(8'h1a, 1'b1, 16'h0);
			chk(q, 32'(i[0]));
		end
		irqs(32'h1);
		hs <= 3'h7;
		ls <= 3'h2;
		start(8'h1b, 1'b0, 16'h8000);
		cyc(40);
		chk(32'({gh, gl}), 32'h0);
		flt_n <= 1'b1;
		cyc(100);
		av(1'b0, gdcr_pkg::HOST_CONFIG_OFS, 32'h0);
		chk(32'({q[3], gh}), 32'h8);
		idle();
		irqs(32'h5);
		for (int i = 0; i < 6; i++) begin
			{hs, ls, src, snk} <= 14'($urandom());
			cyc(8);
			chk(32'({gh, gl}), 32'({hs, ls}));
		end
		// Currents staged at one rising high-side edge, applied at the next
		for (int i = 0; i < 6; i++) begin
			hs <= 3'(i[0]);
			if (i % 2 == 0) {src, snk} <= (i == 0) ? 8'h5a : 8'h3c;
			cyc(8);
			if (i > 2) chk(32'({sco, sko}), (i == 5) ? 32'h3c : 32'h5a);
		end
		{drv_off, src, snk} <= 9'h1a5;
		cyc(8);
		chk(32'({gh, gl}), 32'h0);
		chk(32'({sco, sko}), 32'ha5);
		dev(8'h1b, 1'b0, 16'h8000);
		dev(8'h1b, 1'b1, 16'h0);
		chk(32'(q[15]), 32'h0);
		drv_off <= 1'b0;
		cyc(8);
		dev(8'h1b, 1'b1, 16'h0);
		chk(32'(q[15]), 32'h0);
		dev(8'h1b, 1'b0, 16'h8000);
		pd_flt <= 1'b1;
		cyc(8);
		dev(8'h1b, 1'b1, 16'h0);
		chk(32'(q[15]), 32'h1);
		all_channel_shutdown <= 1'b1;
		cyc(8);
		dev(8'h1b, 1'b1, 16'h0);
		chk(32'({q[15], gh, gl}), 32'h0);
		pd_flt <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			w = 16'($urandom()) & 16'h0f00;
			w[11] = i[1];
			w[8] = i[1] ^ i[0];
			av(1'b1, gdcr_pkg::HOST_CONFIG_OFS, {29'h0, i[0], 2'h3});
			dev(8'h1b, 1'b0, w);
			cyc(2);
			chk(32'({amp_on, hiz, az, ss, ldo, pstop}), 32'({w[11], !w[11], !(w[10] & i[0]),
				1'b1, w[8], w[8]}));
			dev(8'h1b, 1'b1, 16'h0);
			chk(q & 32'hff3e, 32'({w[11:10] & {1'b1, i[0]}, 1'b1, w[8], 8'h06}));
		end
		uv_fm <= 1'b1;
		dev(8'h1b, 1'b0, 16'h0800);
		uv <= 1'b1;
		cyc(8);
		chk(32'({amp_on, hiz}), 32'h1);
		uv_fm <= 1'b0;
		irqs(32'h1);
		dev(8'h1b, 1'b0, 16'h0800);
		irqs(32'h2);
		end_sim();
	end
endmodule // tb
`default_nettype wire
